// ===== pkg/mfp_regs.vh
// register map, field layout, reset values and function codes of the pin configuration block
// assumes the byte-wide register port of the device register file reaches these offsets
`ifndef MFP_REGS_VH
`define MFP_REGS_VH

`define MFP_PIN_ONE_CTRL_ADDR  8'h40
`define MFP_PIN_TWO_CTRL_ADDR  8'h41
`define MFP_CTRL_RESET         8'h00
`define MFP_FUNC_MSB           7
`define MFP_FUNC_LSB           4

`define MFP_FN_OD_HIGH         4'h0
`define MFP_FN_LOW             4'h1
`define MFP_FN_SPECIAL         4'h2
`define MFP_FN_PP_HIGH         4'h3
`define MFP_FN_SEQ_A           4'h4
`define MFP_FN_SEQ_B           4'h5
`define MFP_FN_SEQ_C           4'h6
`define MFP_FN_SEQ_D           4'h7
`define MFP_FN_IN_LEVEL        4'h8
`define MFP_FN_IN_POSEDGE      4'h9
`define MFP_FN_IN_NEGEDGE      4'ha

`define MFP_MR_DEGLITCH_NS     1000
`define MFP_CLK_PERIOD_NS      40

`endif

// ===== src/mfp_sync.v
// two flip-flop synchroniser for one level
// assumes the input may change at any time relative to i_core_clk
`timescale 1ns/1ns
module mfp_sync
(
    input  wire i_core_clk,
    input  wire i_rstn,
    input  wire i_async,
    output wire o_sync
);
    reg meta_reg;
    reg sync_reg;

    // first stage feeds only the second stage
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule

// ===== src/mfp_pin_input.v
// input capture for one multifunction pin: level, rising and falling edge events
// assumes i_pin is already synchronised to i_core_clk
`timescale 1ns/1ns
module mfp_pin_input
(
    input  wire i_core_clk,
    input  wire i_rstn,
    input  wire i_enable,
    input  wire i_pin,
    output reg  o_level,
    output reg  o_rise,
    output reg  o_fall
);
    reg prev_reg;

    // edge pulses only while the pin is configured as an input
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            prev_reg <= 1'b0;
            o_level  <= 1'b0;
            o_rise   <= 1'b0;
            o_fall   <= 1'b0;
        end
        else
        begin
            prev_reg <= i_pin;
            o_level  <= i_enable & i_pin;
            o_rise   <= i_enable & i_pin & ~prev_reg;
            o_fall   <= i_enable & ~i_pin & prev_reg;
        end
    end
endmodule

// ===== src/mfp_pin_config.v
// function selection and pin drive for multifunction pins one and two
// assumes a byte register port decoded by an upstream serial slave, one clock, pins resolved outside
// Functional notes
// RULE1 - pin one codes 0, 1, 3: open-drain high, drive low, push-pull high
// RULE2 - pin one code 2 outputs deglitched copy of active-low manual reset
// RULE3 - pin one codes 4 to 7 push-pull sequencer slot a to d
// RULE4 - pin one inputs: level at 8, rising edge at 9, falling edge at a
// RULE5 - pin two code 1 drives low, code 3 push-pull high
// RULE6 - pin two code 2 is push-pull power-good for power-up sequence
// RULE7 - pin two codes 4 to 7 push-pull sequencer slot a to d
// RULE8 - pin two level input at 8, falling edge at a, code 9 reserved
// RULE9 - pin two control at 41h resets to 00h, open-drain high
// RULE10 - soft reset clears fields; low nibble reads zero; codes b to f reserved
// RULE11 - software writes only defined codes, relies on nothing for reserved ones
`timescale 1ns/1ns
`include "mfp_regs.vh"
module mfp_pin_config
#(
    parameter MR_DEGLITCH_NS = `MFP_MR_DEGLITCH_NS
)
(
    input  wire       i_core_clk,
    input  wire       i_rstn,
    input  wire       i_soft_reset,
    input  wire       i_reg_wr,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    input  wire [3:0] i_seq_slot,
    input  wire       i_power_good,
    input  wire       i_manual_reset_input_n,
    input  wire       i_pin_one_in,
    output reg        o_pin_one_out,
    output reg        o_pin_one_oe,
    input  wire       i_pin_two_in,
    output reg        o_pin_two_out,
    output reg        o_pin_two_oe,
    output wire       o_pin_one_level,
    output wire       o_pin_one_rise,
    output wire       o_pin_one_fall,
    output wire       o_pin_two_level,
    output wire       o_pin_two_fall
);
    localparam [15:0] MR_CYCLES = (MR_DEGLITCH_NS + `MFP_CLK_PERIOD_NS - 1) / `MFP_CLK_PERIOD_NS;

    // reset value of a function field, cut from the byte-wide register reset value
    localparam [7:0]  CTRL_RESET  = `MFP_CTRL_RESET;
    localparam [3:0]  FIELD_RESET = CTRL_RESET[`MFP_FUNC_MSB:`MFP_FUNC_LSB];

    reg  [3:0]  pin_one_function_select_reg;
    reg  [3:0]  pin_two_function_select_reg;
    reg  [15:0] mr_count_reg;
    reg         mr_clean_reg;
    wire        mr_sync;
    wire        pin_one_sync;
    wire        pin_two_sync;
    wire        pin_one_is_in;
    wire        pin_two_is_in;
    wire        pin_one_rise_raw;
    wire        pin_two_level_raw;
    wire        pin_two_rise_unused;

    // a code below 8 drives the pin, defined input codes release it
    function is_output;
        input [3:0] code;
        begin
            is_output = ~code[3];
        end
    endfunction

    // defined input codes; a pin without a rising-edge mode treats that code as reserved
    function is_input;
        input [3:0] code;
        input       has_rise;
        begin
            case (code)
                `MFP_FN_IN_LEVEL:   is_input = 1'b1;
                `MFP_FN_IN_POSEDGE: is_input = has_rise;
                `MFP_FN_IN_NEGEDGE: is_input = 1'b1;
                default:            is_input = 1'b0;
            endcase
        end
    endfunction

    // register address match, shared by the write and read paths
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // sequencer slot level for codes 4 to 7
    function seq_level;
        input [3:0] code;
        input [3:0] slots;
        begin
            seq_level = slots[code[1:0]];
        end
    endfunction

    // function fields, cleared by power-on and soft reset
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pin_one_function_select_reg <= FIELD_RESET; // RULE9
            pin_two_function_select_reg <= FIELD_RESET; // RULE9
        end
        else if (i_soft_reset)
        begin
            pin_one_function_select_reg <= 4'h0; // RULE10
            pin_two_function_select_reg <= 4'h0; // RULE10
        end
        else if (i_reg_wr)
        begin
            if (addr_hit(i_reg_addr, `MFP_PIN_ONE_CTRL_ADDR))
                pin_one_function_select_reg <= i_reg_wdata[`MFP_FUNC_MSB:`MFP_FUNC_LSB];
            if (addr_hit(i_reg_addr, `MFP_PIN_TWO_CTRL_ADDR)) // RULE9
                pin_two_function_select_reg <= i_reg_wdata[`MFP_FUNC_MSB:`MFP_FUNC_LSB];
        end
    end

    // read back; low nibble and unmapped addresses read zero
    always @*
    begin
        o_reg_rdata = 8'h00;
        if (addr_hit(i_reg_addr, `MFP_PIN_ONE_CTRL_ADDR))
            o_reg_rdata = {pin_one_function_select_reg, 4'h0}; // RULE10
        else if (addr_hit(i_reg_addr, `MFP_PIN_TWO_CTRL_ADDR))
            o_reg_rdata = {pin_two_function_select_reg, 4'h0}; // RULE10
    end

    // synchronisers for the pins and the manual reset input
    mfp_sync u_sync_mr
    (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (i_manual_reset_input_n),
        .o_sync     (mr_sync)
    );

    mfp_sync u_sync_one
    (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (i_pin_one_in),
        .o_sync     (pin_one_sync)
    );

    mfp_sync u_sync_two
    (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_async    (i_pin_two_in),
        .o_sync     (pin_two_sync)
    );

    // manual reset deglitch: level must hold MR_CYCLES before the clean copy follows
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            mr_count_reg <= 16'h0000;
            mr_clean_reg <= 1'b1;
        end
        else if (mr_sync == mr_clean_reg)
            mr_count_reg <= 16'h0000;
        else if (mr_count_reg >= MR_CYCLES - 16'h0001)
        begin
            mr_count_reg <= 16'h0000;
            mr_clean_reg <= mr_sync; // RULE2
        end
        else
            mr_count_reg <= mr_count_reg + 16'h0001;
    end

    // input modes enable the capture logic
    // reserved codes leave capture disabled, so they raise no events
    assign pin_one_is_in = is_input(pin_one_function_select_reg, 1'b1); // RULE4
    assign pin_two_is_in = is_input(pin_two_function_select_reg, 1'b0); // RULE8


    mfp_pin_input u_in_one
    (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_enable   (pin_one_is_in),
        .i_pin      (pin_one_sync),
        .o_level    (o_pin_one_level),
        .o_rise     (pin_one_rise_raw),
        .o_fall     (o_pin_one_fall)
    );

    mfp_pin_input u_in_two
    (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_enable   (pin_two_is_in),
        .i_pin      (pin_two_sync),
        .o_level    (pin_two_level_raw),
        .o_rise     (pin_two_rise_unused),
        .o_fall     (o_pin_two_fall)
    );

    // edge pulses in every enabled input mode, not just the edge's own code; level readable in every input mode
    assign o_pin_one_rise  = pin_one_rise_raw; // RULE4
    assign o_pin_two_level = pin_two_level_raw; // RULE8

    // pin one drive; open-drain high releases the pin
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pin_one_out <= 1'b0;
            o_pin_one_oe  <= 1'b0;
        end
        else
        begin
            o_pin_one_out <= 1'b0;
            o_pin_one_oe  <= 1'b0;
            case (pin_one_function_select_reg)
                `MFP_FN_OD_HIGH:
                    o_pin_one_oe <= 1'b0; // RULE1
                `MFP_FN_LOW:
                    o_pin_one_oe <= 1'b1; // RULE1
                `MFP_FN_SPECIAL:
                begin
                    o_pin_one_out <= mr_clean_reg; // RULE2
                    o_pin_one_oe  <= 1'b1;
                end
                `MFP_FN_PP_HIGH:
                begin
                    o_pin_one_out <= 1'b1; // RULE1
                    o_pin_one_oe  <= 1'b1;
                end
                `MFP_FN_SEQ_A, `MFP_FN_SEQ_B, `MFP_FN_SEQ_C, `MFP_FN_SEQ_D:
                begin
                    o_pin_one_out <= seq_level(pin_one_function_select_reg, i_seq_slot); // RULE3
                    o_pin_one_oe  <= 1'b1;
                end
                default:
                    o_pin_one_oe <= 1'b0; // RULE4
            endcase
        end
    end

    // pin two drive
    always @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_pin_two_out <= 1'b0;
            o_pin_two_oe  <= 1'b0;
        end
        else
        begin
            o_pin_two_out <= 1'b0;
            o_pin_two_oe  <= 1'b0;
            case (pin_two_function_select_reg)
                `MFP_FN_OD_HIGH:
                    o_pin_two_oe <= 1'b0; // RULE9
                `MFP_FN_LOW:
                    o_pin_two_oe <= 1'b1; // RULE5
                `MFP_FN_SPECIAL:
                begin
                    o_pin_two_out <= i_power_good; // RULE6
                    o_pin_two_oe  <= 1'b1;
                end
                `MFP_FN_PP_HIGH:
                begin
                    o_pin_two_out <= 1'b1; // RULE5
                    o_pin_two_oe  <= 1'b1;
                end
                `MFP_FN_SEQ_A, `MFP_FN_SEQ_B, `MFP_FN_SEQ_C, `MFP_FN_SEQ_D:
                begin
                    o_pin_two_out <= seq_level(pin_two_function_select_reg, i_seq_slot); // RULE7
                    o_pin_two_oe  <= is_output(pin_two_function_select_reg);
                end
                default:
                    o_pin_two_oe <= 1'b0; // RULE10
            endcase
        end
    end
endmodule

// ===== bench/mfp_pin_model.sv
// far side of one multifunction pin: external logic plus the board pull-up
// assumes oe high means the block drives the wire
`timescale 1ns/1ns
module mfp_pin_model
(
    input  wire i_oe,
    input  wire i_out,
    input  wire i_ext_en,
    input  wire i_ext_val,
    output wire o_wire
);
    // released wire with no external driver floats to the pull-up level
    assign o_wire = i_oe ? i_out : (i_ext_en ? i_ext_val : 1'b1);
endmodule

// ===== bench/mfp_pin_config_checker.sv
// port-level checks of the pin configuration block
// assumes one clock and the asynchronous active-low reset
`timescale 1ns/1ns
module mfp_pin_config_checker
(
    input wire       i_core_clk,
    input wire       i_rstn,
    input wire       i_soft_reset,
    input wire       i_reg_wr,
    input wire [7:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire [3:0] i_seq_slot,
    input wire       i_power_good,
    input wire       o_pin_one_out,
    input wire       o_pin_one_oe,
    input wire       o_pin_two_out,
    input wire       o_pin_two_oe,
    input wire       o_pin_one_rise,
    input wire       o_pin_two_fall
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    // accepted writes per register
    wire       w1 = i_reg_wr && !i_soft_reset && i_reg_addr == 8'h40;
    wire       w2 = i_reg_wr && !i_soft_reset && i_reg_addr == 8'h41;
    wire [3:0] c  = i_reg_wdata[7:4];
    reg  [1:0] one_sel_reg;
    // slot index of the last pin one write, for the sequencer check
    always @(posedge i_core_clk)
    begin
        if (w1)
            one_sel_reg <= c[1:0];
    end
    chk_one_low: assert property (w1 && c == 4'h1 |-> ##2 o_pin_one_oe && !o_pin_one_out)
        else $error("pin one not driven low");
    chk_one_od_high: assert property (w1 && c == 4'h0 |-> ##2 !o_pin_one_oe)
        else $error("pin one not released");
    chk_two_pp_high: assert property (w2 && c == 4'h3 |-> ##2 o_pin_two_oe && o_pin_two_out)
        else $error("pin two not push-pull high");
    chk_two_pg_out: assert property (w2 && c == 4'h2 |-> ##2 o_pin_two_oe && o_pin_two_out == $past(i_power_good))
        else $error("pin two not power good");
    chk_one_seq_slot: assert property (w1 && c[3:2] == 2'b01 |-> ##2 o_pin_one_oe && o_pin_one_out == $past(i_seq_slot[one_sel_reg]))
        else $error("pin one sequencer slot wrong");
    chk_two_reserved: assert property (w2 && c == 4'h9 |-> ##2 !o_pin_two_oe)
        else $error("pin two reserved code drives");
    chk_low_nibble: assert property (o_reg_rdata[3:0] == 4'h0)
        else $error("low nibble not zero");
    chk_soft_clear: assert property (i_soft_reset |=> o_reg_rdata == 8'h00)
        else $error("soft reset left a field");
    chk_rise_pulse: assert property ($rose(o_pin_one_rise) |=> !o_pin_one_rise)
        else $error("rise pulse too long");
    cover_mr_code: cover property (w1 && c == 4'h2);
    cover_rise: cover property (o_pin_one_rise);
    cover_two_fall: cover property (o_pin_two_fall);
endmodule
bind mfp_pin_config mfp_pin_config_checker u_chk (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
    .i_soft_reset(i_soft_reset), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_seq_slot(i_seq_slot), .i_power_good(i_power_good),
    .o_pin_one_out(o_pin_one_out), .o_pin_one_oe(o_pin_one_oe), .o_pin_two_out(o_pin_two_out),
    .o_pin_two_oe(o_pin_two_oe), .o_pin_one_rise(o_pin_one_rise), .o_pin_two_fall(o_pin_two_fall));

// ===== bench/tb_top.sv
// self-checking bench of the pin configuration block with two pin models
// assumes a 25 MHz clock and a short manual reset deglitch
`timescale 1ns/1ns
module tb_top;
    reg        clk, rstn, srst, wr, pg, mrn, e1en, e1v, e2en, e2v;
    reg  [7:0] addr, wdata;
    reg  [3:0] slot, c;
    reg  [2:0] hit;
    wire [7:0] rdata;
    wire       o1, oe1, o2, oe2, p1, p2, lv1, r1, f1, lv2, f2;
    integer    err_count, cmp_count, seed, i;
    mfp_pin_config #(.MR_DEGLITCH_NS(200)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_soft_reset(srst),
        .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_seq_slot(slot),
        .i_power_good(pg), .i_manual_reset_input_n(mrn), .i_pin_one_in(p1), .o_pin_one_out(o1),
        .o_pin_one_oe(oe1), .i_pin_two_in(p2), .o_pin_two_out(o2), .o_pin_two_oe(oe2),
        .o_pin_one_level(lv1), .o_pin_one_rise(r1), .o_pin_one_fall(f1), .o_pin_two_level(lv2),
        .o_pin_two_fall(f2));
    mfp_pin_model u_m1 (.i_oe(oe1), .i_out(o1), .i_ext_en(e1en), .i_ext_val(e1v), .o_wire(p1));
    mfp_pin_model u_m2 (.i_oe(oe2), .i_out(o2), .i_ext_en(e2en), .i_ext_val(e2v), .o_wire(p2));
    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task chk(input [8*8-1:0] name, input [7:0] seen, input [7:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_count = err_count + 1;
            $display("unexpected %0s expected %h seen %h", name, exp, seen);
        end
    endtask
    task report_and_stop;
        $display("mismatches %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one register write, new slot and power-good levels launched with it
    task wr_reg(input [7:0] a, input [7:0] d);
        @(posedge clk);
        #1;
        wr = 1'b1; addr = a; wdata = d;
        slot = $random(seed); pg = $random(seed);
        @(posedge clk);
        #1;
        wr = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // expected {oe, out}; a released pin reads as 00
    function [1:0] exp_drive(input two, input [3:0] k, input [3:0] s, input p);
        case (k)
            4'h1: exp_drive = 2'b10;
            4'h2: exp_drive = two ? {1'b1, p} : 2'b11;
            4'h3: exp_drive = 2'b11;
            4'h4, 4'h5, 4'h6, 4'h7: exp_drive = {1'b1, s[k[1:0]]};
            default: exp_drive = 2'b00;
        endcase
    endfunction
    // collect edge pulses over eight cycles
    task pulses(input [2:0] exp);
        hit = 3'b000;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            hit = hit | {r1, f1, f2};
        end
        chk("edges", {5'h00, hit}, {5'h00, exp});
    endtask
    // watchdog
    initial
    begin
        #400000;
        err_count = err_count + 1;
        report_and_stop;
    end
    initial
    begin
        err_count = 0; cmp_count = 0; seed = 4655;
        rstn = 1'b0; srst = 1'b0; wr = 1'b0; addr = 8'h40; wdata = 8'h00; slot = 4'h0; pg = 1'b0;
        mrn = 1'b1; e1en = 1'b0; e1v = 1'b1; e2en = 1'b0; e2v = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        rstn = 1'b1;
        #1;
        chk("reg40", rdata, 8'h00);
        addr = 8'h41;
        #1;
        chk("reg41", rdata, 8'h00);
        chk("oe2", {7'h00, oe2}, 8'h00);
        $display("test reset done");
        // every code on both pins, random low nibble and levels
        for (i = 0; i < 32; i = i + 1)
        begin
            c = i[3:0];
            wr_reg(i[4] ? 8'h41 : 8'h40, {c, 4'($random(seed))});
            chk("drive1", {6'h00, oe1, oe1 & o1}, {6'h00, exp_drive(1'b0, i[4] ? 4'h0 : c, slot, pg)});
            chk("drive2", {6'h00, oe2, oe2 & o2}, {6'h00, exp_drive(1'b1, i[4] ? c : 4'h0, slot, pg)});
            chk("readback", rdata, {c, 4'h0});
            if (i == 15)
                wr_reg(8'h40, 8'h00);
        end
        wr_reg(8'h41, 8'h00);
        $display("test codes done");
        // glitch is filtered, a long low passes to pin one
        wr_reg(8'h40, 8'h2f);
        mrn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        mrn = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk("mr_glitch", {7'h00, o1}, 8'h01);
        mrn = 1'b0;
        repeat (14) @(posedge clk);
        #1;
        chk("mr_low", {6'h00, oe1, o1}, 8'h02);
        mrn = 1'b1;
        $display("test manual reset done");
        // edge inputs: pin one rising, pin two falling, then pin one falling
        e1en = 1'b1; e1v = 1'b0; e2en = 1'b1; e2v = 1'b1;
        wr_reg(8'h40, 8'h90);
        wr_reg(8'h41, 8'ha0);
        pulses(3'b000);
        e1v = 1'b1; e2v = 1'b0;
        pulses(3'b101);
        chk("level", {6'h00, lv1, lv2}, 8'h02);
        wr_reg(8'h40, 8'ha0);
        e1v = 1'b0;
        pulses(3'b010);
        $display("test edges done");
        // unmapped write ignored, then soft reset clears both fields
        wr_reg(8'h42, 8'hf0);
        chk("unmapped", rdata, 8'h00);
        addr = 8'h40;
        #1;
        chk("kept40", rdata, 8'ha0);
        wr_reg(8'h41, 8'h30);
        srst = 1'b1;
        @(posedge clk);
        #1;
        srst = 1'b0;
        addr = 8'h41;
        repeat (2) @(posedge clk);
        #1;
        chk("soft41", rdata, 8'h00);
        chk("soft_oe", {6'h00, oe1, oe2}, 8'h00);
        $display("test soft reset done");
        report_and_stop;
    end
endmodule
